// ===== verilog/power_good_reset_generator.v
// Purpose: Open-drain power-good reset generator with host watchdog
// Assumes: 100 MHz clock; pins pass three flip-flop synchronisers
// Notes:   Register reached by a simple byte port at its fixed offset
// Summary of operation
// (RULE_01) Power-good is open drain; three supply trips always pull it low.
// (RULE_02) Control bit 1 set adds thermal trip as a source; default excluded.
// (RULE_03) Control bit 0 clear keeps watchdog a source; set disables it.
// (RULE_04) Strap 1 gives 200 ms pulse width, strap 0 gives 500 ms.
// (RULE_05) Strap captured when PCI reset or main-supply reset deasserts.
// (RULE_06) Control bit 2 is the watchdog kick; bits 7 to 3 reserved.
// (RULE_07) Power-good stays low at least 100 ms after rails valid.
// (RULE_08) Kick bit cleared by main-supply reset; host reads and writes it.
// (RULE_09) Watchdog enable is a register bit; enabled watchdog is a source.
// (RULE_10) Watchdog counter held reset while main-supply reset is asserted.
// (RULE_11) Counter starts after main reset release once kick bit is one.
// (RULE_12) Each kick toggle reloads a full 1.6 s period; host must kick.
// (RULE_13) Expiry without kick emits a 125 ms watchdog pulse.
// (RULE_14) After timeout no new cycle until the host toggles again.
// (RULE_15) Power-good drops promptly when supply-on request pin goes high.
// (RULE_16) Power-good drops promptly when a monitored supply trips.
// (RULE_17) Hold low while any source active, release after pulse width.
`timescale 1ns/1ps
`default_nettype none
`include "pg_reset_defines.vh"
module power_good_reset_generator #(
  parameter integer TICK_DIV = `TICK_CYCLES
) (
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire       main_por_i,
  input  wire       pci_reset_n_i,
  input  wire       pulse_width_strap_i,
  input  wire       trip_main_3v3_i,
  input  wire       trip_standby_3v3_i,
  input  wire       trip_5v_i,
  input  wire       thermal_trip_n_i,
  input  wire       supply_on_request_n_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  output wire       power_good_output_o,
  output wire       power_good_output_oe_n_o,
  output wire       wd_pulse_o
);
  localparam [1:0] WD_IDLE = 2'd0;
  localparam [1:0] WD_RUN  = 2'd1;
  localparam [1:0] WD_PULS = 2'd2;
  localparam [1:0] WD_DONE = 2'd3;

  localparam [10:0] WD_PERIOD = `WD_PERIOD_MS;
  localparam [10:0] WD_PULSE  = `WD_PULSE_MS;
  localparam [9:0]  PW_SHORT  = `PULSE_SHORT_MS;
  localparam [9:0]  PW_LONG   = `PULSE_LONG_MS;
  localparam [9:0]  PW_HOLD   = `POWER_HOLD_MS;

  // Three-stage synchronisers; a change counts once stages two and three agree
  // Reset levels match idle pins (POR asserted, PCI reset released, supplies
  // good, no thermal trip, supply on, strap 200 ms) so no false edge follows reset
  localparam integer NPIN     = 8;
  localparam [7:0]   PIN_IDLE = 8'hA3;
  wire [7:0] pin_raw;
  wire [7:0] pin_r;
  assign pin_raw = {pulse_width_strap_i, supply_on_request_n_i, thermal_trip_n_i, trip_5v_i,
                    trip_standby_3v3_i, trip_main_3v3_i, pci_reset_n_i, main_por_i};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          s1_r  <= PIN_IDLE[gi];
          s2_r  <= PIN_IDLE[gi];
          s3_r  <= PIN_IDLE[gi];
          lvl_r <= PIN_IDLE[gi];
        end
        else
        begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // A level that disagrees is held, so a slow edge counts only once
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign pin_r[gi] = lvl_r;
    end
  endgenerate
  wire por_s   = pin_r[0];
  wire pcirn_s = pin_r[1];
  wire therm_s = ~pin_r[5];
  wire ps_off  = pin_r[6];
  wire strap_s = pin_r[7];

  wire ms_tick;
  pg_ms_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (ms_tick)
  );

  // Edge history for the strap-capture events
  reg por_d_r;
  reg pcirn_d_r;
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      por_d_r   <= 1'b1;
      pcirn_d_r <= 1'b1;
    end
    else
    begin
      por_d_r   <= por_s;
      pcirn_d_r <= pcirn_s;
    end
  end
  wire por_rel   = por_d_r & ~por_s;
  wire pcirn_rel = ~pcirn_d_r & pcirn_s;

  // (RULE_05) strap capture edge
  // Strap shares the reset synchroniser delay, so both line up at the edge
  reg strap_r;
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      strap_r <= 1'b1;
    else if (por_rel | pcirn_rel)
      strap_r <= strap_s;
  end

  // Control register
  localparam [7:0] CTRL_INIT = `CTRL_RESET;
  reg [2:0] ctrl_r;
  wire      reg_hit = (reg_addr_i == `CTRL_OFFSET);
  wire      wr_ctrl = reg_wr_i & reg_hit;
  // (RULE_08) kick cleared on POR
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      ctrl_r <= CTRL_INIT[2:0];
    else if (por_s)
      ctrl_r[`CTRL_KICK_BIT] <= 1'b0;
    else if (wr_ctrl)
      ctrl_r <= reg_wdata_i[2:0];
  end
  wire wd_dis   = ctrl_r[`CTRL_WD_DIS_BIT];
  wire therm_en = ctrl_r[`CTRL_THERM_BIT];
  wire kick     = ctrl_r[`CTRL_KICK_BIT];

  // (RULE_06) read path, reserved zero
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i & reg_hit)
      reg_rdata_o <= {5'h00, ctrl_r};
    else if (reg_rd_i)
      reg_rdata_o <= 8'h00;
  end

  // Kick toggle detect
  reg kick_d_r;
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      kick_d_r <= 1'b0;
    else
      kick_d_r <= kick;
  end
  wire kick_tgl = kick ^ kick_d_r;

  // Watchdog state machine
  reg [1:0]  wd_st_r;
  reg [10:0] wd_cnt_r;
  always @(posedge clk_sys_i)
  begin
    // (RULE_10) held in reset
    if (sys_rst_i | por_s)
    begin
      wd_st_r  <= WD_IDLE;
      wd_cnt_r <= 11'h000;
    end
    else
    begin
      case (wd_st_r)
        WD_IDLE:
        begin
          // (RULE_11) start once kick set
          if (kick)
          begin
            wd_st_r  <= WD_RUN;
            wd_cnt_r <= WD_PERIOD;
          end
        end
        WD_RUN:
        begin
          // (RULE_12) toggle reloads period
          if (kick_tgl)
            wd_cnt_r <= WD_PERIOD;
          else if (ms_tick)
          begin
            if (wd_cnt_r == 11'h001)
            begin
              // (RULE_13) expiry starts pulse
              wd_st_r  <= WD_PULS;
              wd_cnt_r <= WD_PULSE;
            end
            else
              wd_cnt_r <= wd_cnt_r - 11'h001;
          end
        end
        // Toggles during the pulse are not kept; the host toggles again after it
        WD_PULS:
        begin
          if (ms_tick)
          begin
            if (wd_cnt_r == 11'h001)
              wd_st_r <= WD_DONE;
            else
              wd_cnt_r <= wd_cnt_r - 11'h001;
          end
        end
        WD_DONE:
        begin
          // (RULE_14) wait for toggle
          if (kick_tgl)
          begin
            wd_st_r  <= WD_RUN;
            wd_cnt_r <= WD_PERIOD;
          end
        end
        default:
          wd_st_r <= WD_IDLE;
      endcase
    end
  end
  wire wd_fire = (wd_st_r == WD_PULS);
  assign wd_pulse_o = wd_fire;

  // (RULE_01) supply trips always sources
  wire supply_bad = pin_r[2] | pin_r[3] | pin_r[4];
  // (RULE_02) (RULE_03) (RULE_09) optional sources
  wire src_active = supply_bad | ps_off | (therm_en & therm_s) | (~wd_dis & wd_fire);

  // Release timer: width is the strap pulse, never below the rail hold time
  wire [9:0] pw_sel = strap_r ? PW_SHORT : PW_LONG;
  wire [9:0] pw_len = (pw_sel > PW_HOLD) ? pw_sel : PW_HOLD;
  reg  [9:0] rel_cnt_r;
  reg        pg_r;
  always @(posedge clk_sys_i)
  begin
    // (RULE_15) (RULE_16) prompt drop
    if (sys_rst_i | src_active)
    begin
      pg_r      <= 1'b0;
      rel_cnt_r <= 10'h000;
    end
    // (RULE_04) (RULE_07) (RULE_17) timed release
    else if (!pg_r && ms_tick)
    begin
      // At or past the end: a strap recaptured mid-count must not wrap the timer
      if (rel_cnt_r >= pw_len - 10'h001)
        pg_r <= 1'b1;
      else
        rel_cnt_r <= rel_cnt_r + 10'h001;
    end
  end

  // Open drain: output always low, enable low while pulling the pin down
  assign power_good_output_o      = 1'b0;
  assign power_good_output_oe_n_o = pg_r;
endmodule
`default_nettype wire

// ===== pkg/pg_reset_defines.vh
// Purpose: Constants for the power-good reset generator
// Assumes: 100 MHz system clock
// Notes:   Times are in ms, the tick period in us; cycle counts are derived from them
`ifndef PG_RESET_DEFINES_VH
`define PG_RESET_DEFINES_VH
`define CLK_HZ            100000000
`define TICK_US           1000
`define TICK_CYCLES       ((`CLK_HZ / 1000000) * `TICK_US)
`define CTRL_OFFSET       8'h1D
`define CTRL_RESET        8'h00
`define CTRL_WD_DIS_BIT   0
`define CTRL_THERM_BIT    1
`define CTRL_KICK_BIT     2
`define PULSE_SHORT_MS    200
`define PULSE_LONG_MS     500
`define POWER_HOLD_MS     100
`define WD_PERIOD_MS      1600
`define WD_PULSE_MS       125
`endif

// ===== verilog/pg_ms_tick.v
// Purpose: Divider giving a one-cycle pulse every millisecond
// Assumes: clk_sys_i at 100 MHz
// Notes:   Serves as the slow timebase for all timing
`timescale 1ns/1ps
`default_nettype none
module pg_ms_tick #(
  parameter integer DIV = 100000
) (
  input  wire clk_sys_i,
  input  wire sys_rst_i,
  output reg  tick_o
);
  reg [31:0] cnt_r;

  // Free-running divider
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b0;
    end
    else if (cnt_r == DIV - 1)
    begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/pg_board.sv
// Purpose: Board side of the power-good line
// Assumes: Pull-up resistor on the line
// Notes:   Released line reads high
`timescale 1ns/1ps
`default_nettype none
module pg_board (
  input  wire logic pg_data_i,
  input  wire logic pg_oe_n_i,
  output wire logic pg_pin_o
);
  // open drain pull-up
  // Pull-up lifts the line once the device lets go
  assign pg_pin_o = pg_oe_n_i ? 1'h1 : pg_data_i;
endmodule
`default_nettype wire

// ===== tb/pg_reset_properties.sv
// Purpose: Port checks for the power-good generator
// Assumes: TICK_DIV cycles per ms tick
// Notes:   Widths allow one tick of slack
`timescale 1ns/1ps
`default_nettype none
module pg_reset_props #(
  parameter integer TICK_DIV = 10
) (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       main_por_i,
  input wire logic       trip_main_3v3_i,
  input wire logic       trip_standby_3v3_i,
  input wire logic       trip_5v_i,
  input wire logic       supply_on_request_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       power_good_output_o,
  input wire logic       power_good_output_oe_n_o,
  input wire logic       wd_pulse_o
);
  integer low_r;
  integer wdc_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Run lengths of the low line and the watchdog pulse
  always @(posedge clk_sys_i)
  begin
    low_r <= (sys_rst_i || power_good_output_oe_n_o) ? 0 : low_r + 1;
    wdc_r <= (sys_rst_i || !wd_pulse_o) ? 0 : wdc_r + 1;
  end
  a_od_data_low: assert property (power_good_output_o == 1'h0)
    else $error("power-good data not low");
  a_trip_pulls_low: assert property (
    $rose(trip_main_3v3_i | trip_standby_3v3_i | trip_5v_i)
    |-> ##[1:8] !power_good_output_oe_n_o)
    else $error("trip did not pull line low");
  a_supply_off_low: assert property (
    $rose(supply_on_request_n_i) |-> ##[1:8] !power_good_output_oe_n_o)
    else $error("supply off did not pull line low");
  a_hold_min_low: assert property (
    $rose(power_good_output_oe_n_o) |-> low_r >= 99 * TICK_DIV)
    else $error("line released too early");
  a_wd_pulse_width: assert property (
    $fell(wd_pulse_o) |-> wdc_r >= 124 * TICK_DIV && wdc_r <= 126 * TICK_DIV)
    else $error("watchdog pulse width wrong");
  a_reserved_zero: assert property (reg_rd_i |=> reg_rdata_o[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_other_addr_zero: assert property (
    reg_rd_i && reg_addr_i != 8'h1D |=> reg_rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  a_por_kick_clear: assert property (
    main_por_i[*8] ##0 reg_rd_i |=> !reg_rdata_o[2])
    else $error("kick bit set under reset");
  a_por_wd_quiet: assert property (main_por_i[*8] |-> !wd_pulse_o)
    else $error("watchdog pulse under reset");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  cover property ($rose(wd_pulse_o));
  cover property ($rose(power_good_output_oe_n_o));
  cover property (reg_rd_i && reg_addr_i == 8'h1D);
endmodule
bind power_good_reset_generator pg_reset_props #(.TICK_DIV(TICK_DIV)) u_props (
  .clk_sys_i, .sys_rst_i, .main_por_i, .trip_main_3v3_i, .trip_standby_3v3_i,
  .trip_5v_i, .supply_on_request_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
  .power_good_output_o, .power_good_output_oe_n_o, .wd_pulse_o);
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Directed bench for the power-good generator
// Assumes: 1 ms tick shortened to 10 cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 0, rst = 1, por = 1, pci_n = 1, strap = 1, therm_n = 1;
  logic [3:0] src = 4'h0; // Supply off, 5V, standby, main
  logic [7:0] addr = 8'h00, wdat = 8'h00;
  logic       wr = 0, rd = 0;
  wire  [7:0] rdat;
  wire        pg_d, pg_oe_n, wdp, pin;
  integer     bad_count = 0, comparisons = 0, i;
  always #5 clk = ~clk;
  power_good_reset_generator #(.TICK_DIV(10)) u_dut (.clk_sys_i(clk), .sys_rst_i(rst),
    .main_por_i(por), .pci_reset_n_i(pci_n), .pulse_width_strap_i(strap),
    .trip_main_3v3_i(src[0]), .trip_standby_3v3_i(src[1]), .trip_5v_i(src[2]),
    .thermal_trip_n_i(therm_n), .supply_on_request_n_i(src[3]), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .power_good_output_o(pg_d), .power_good_output_oe_n_o(pg_oe_n), .wd_pulse_o(wdp));
  pg_board u_brd (.pg_data_i(pg_d), .pg_oe_n_i(pg_oe_n), .pg_pin_o(pin));
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdat = d;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    cyc(1);
    cmp(rdat, exp);
  endtask
  // Bounded wait for a line level; a miss ends the run
  task automatic wait_pin(input logic exp, input integer n);
    while (pin !== exp && n > 0)
    begin
      cyc(1);
      n--;
    end
    cmp({7'h00, pin}, {7'h00, exp});
    if (pin !== exp)
      print_verdict();
  endtask
  initial
  begin
    cyc(8);
    rst = 0;
    // Reads fall late enough under POR to reach the kick-clear check
    cyc(10);
    reg_rd(8'h1D, 8'h00);
    reg_wr(8'h1D, 8'h04);
    reg_rd(8'h1D, 8'h00);
    reg_rd(8'h33, 8'h00);
    por = 0;
    cyc(1900);
    wait_pin(0, 0);
    wait_pin(1, 300);
    reg_wr(8'h1D, 8'hFB);
    reg_rd(8'h1D, 8'h03);
    reg_rd(8'h33, 8'h00);
    therm_n = 0;
    wait_pin(0, 20);
    therm_n = 1;
    wait_pin(1, 2300);
    reg_wr(8'h1D, 8'h01);
    therm_n = 0;
    cyc(20);
    wait_pin(1, 0);
    therm_n = 1;
    for (i = 0; i < 4; i++)
    begin
      src = 4'h1 << i;
      wait_pin(0, 20);
      src = 4'h0;
      cyc(1900);
      wait_pin(0, 0);
      wait_pin(1, 300);
    end
    // Long width is latched by the PCI reset release only
    strap = 0;
    pci_n = 0;
    cyc(10);
    pci_n = 1;
    cyc(10);
    strap = 1;
    src = 4'h4;
    cyc(20);
    src = 4'h0;
    cyc(4800);
    wait_pin(0, 0);
    wait_pin(1, 400);
    reg_wr(8'h1D, 8'h04);
    cyc(12000);
    reg_wr(8'h1D, 8'h00);
    cyc(12000);
    wait_pin(1, 0);
    wait_pin(0, 4100);
    cmp({7'h00, wdp}, 8'h01);
    // Pulse, then the 500 ms width still latched from the PCI release
    cyc(6000);
    wait_pin(0, 0);
    wait_pin(1, 400);
    cyc(11500);
    cmp({7'h00, wdp}, 8'h00);
    wait_pin(1, 0);
    // Mid-run POR stops a running watchdog and clears the kick
    reg_wr(8'h1D, 8'h04);
    cyc(100);
    por = 1;
    cyc(20);
    reg_rd(8'h1D, 8'h00);
    por = 0;
    cyc(16500);
    cmp({7'h00, wdp}, 8'h00);
    wait_pin(1, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
